// >>> rtl/usd_port.v
// UART data port: shadow receive/transmit aliases, serial and infrared
`timescale 1ns/1ps
`include "usd_regs.vh"

// Functional notes
// R1: Sixteen word addresses alias receive data on read, transmit on write.
// R2: Read returns received byte in bits 7:0, serial or infrared input.
// R3: Read data valid only while the receive data ready flag is set.
// R4: FIFOs off: new character overwrites unread one and flags overrun.
// R5: FIFOs on: read returns the oldest receive FIFO entry.
// R6: Receive FIFO full: keep contents, drop new character, flag overrun.
// R7: Written data goes out on serial output or active-low infrared output.
// R8: Host writes only while the transmit holding empty flag is set.
// R9: FIFOs off: one written character clears transmit holding empty.
// R10: FIFOs off: further write before empty overwrites the pending char.
// R11: FIFOs on: writes accepted until the 16-entry transmit FIFO fills.
// R12: Write while transmit FIFO is full is discarded, contents untouched.
// R13: Bits 15:8 reserved, read as zero, writes ignored.
module usd_port (
  input  wire        core_clk,
  input  wire        sys_rst,
  input  wire [31:0] addr,
  input  wire [31:0] wr_data,
  input  wire        wr_en,
  input  wire        rd_en,
  output reg  [31:0] rd_data,
  input  wire        sin,
  input  wire        sir_in,
  output reg         sout,
  output reg         sir_out_n,
  output reg         irq
);

  localparam ST_IDLE  = 2'd0;
  localparam ST_START = 2'd1;
  localparam ST_DATA  = 2'd2;
  localparam ST_STOP  = 2'd3;

  // Word-aligned hit in the sixteen alias locations
  function is_shadow;
    input [31:0] a;
    begin
      is_shadow = (a >= `USD_SHADOW_BASE) &&
                  (a < (`USD_SHADOW_BASE + `USD_SHADOW_SPAN)) &&
                  (a[1:0] == 2'b00);
    end
  endfunction

  reg  [1:0]  fifo_control_reg;
  reg  [15:0] divisor;
  reg  [15:0] div_cnt;
  reg         tick;
  reg  [2:0]  irq_status;
  reg  [2:0]  irq_mask;
  reg         overrun;
  reg         tx_holding_empty_q;
  reg  [7:0]  rx_buffer_reg;
  reg         rx_buf_valid;
  reg  [7:0]  tx_holding_reg;
  reg         thr_full;
  reg  [1:0]  rx_state;
  reg  [3:0]  rx_tick;
  reg  [2:0]  rx_bit;
  reg  [7:0]  rx_shift;
  reg         rx_done;
  reg  [7:0]  rx_byte;
  reg         ir_hit;
  reg  [1:0]  tx_state;
  reg  [3:0]  tx_tick;
  reg  [2:0]  tx_bit;
  reg  [7:0]  tx_shift;
  reg         tx_level;
  reg  [2:0]  next_irq_status;

  wire        fifo_en = fifo_control_reg[`USD_CTRL_FIFO_EN];
  wire        ir_mode = fifo_control_reg[`USD_CTRL_IR_MODE];
  wire        sh_rd   = rd_en && is_shadow(addr); // R1
  wire        sh_wr   = wr_en && is_shadow(addr); // R1
  wire        ctrl_wr = wr_en && (addr == `USD_CTRL_ADDR);
  wire        flush   = ctrl_wr && (wr_data[`USD_CTRL_FIFO_EN] != fifo_en);
  wire        rxf_ready;
  wire        rxf_valid;
  wire [7:0]  rxf_data;
  wire        txf_ready;
  wire        txf_valid;
  wire [7:0]  txf_data;

  // Receive line level: infrared counts a seen pulse as a zero bit
  wire rx_level  = ir_mode ? ~(ir_hit | sir_in) : sin; // R2
  wire rx_sample = tick && (((rx_state == ST_START) &&
                   (rx_tick == `USD_TICK_MID)) ||
                   (((rx_state == ST_DATA) || (rx_state == ST_STOP)) &&
                   (rx_tick == `USD_TICK_LAST)));
  wire rx_drop   = rx_done && fifo_en && !rxf_ready;           // R6
  wire oe_ev     = rx_drop ||
                   (rx_done && !fifo_en && rx_buf_valid && !sh_rd); // R4
  wire rx_ev     = rx_done && !rx_drop;
  wire dr        = fifo_en ? rxf_valid : rx_buf_valid;         // R3
  wire tx_holding_empty      = fifo_en ? !txf_valid : !thr_full;
  wire tx_avail  = fifo_en ? txf_valid : thr_full;
  wire tx_load   = (tx_state == ST_IDLE) && tx_avail;
  wire [7:0] rx_head = fifo_en ? rxf_data : rx_buffer_reg;     // R5

  // Receive FIFO: pushes are refused while full, so the head survives
  usd_fifo u_rx_fifo (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .flush     (flush),
    .in_valid  (rx_done && fifo_en),
    .in_data   (rx_byte),
    .in_ready  (rxf_ready),
    .out_valid (rxf_valid),
    .out_data  (rxf_data),
    .out_ready (sh_rd && fifo_en)
  );

  // Transmit FIFO: a write when full is simply not taken
  usd_fifo u_tx_fifo (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .flush     (flush),
    .in_valid  (sh_wr && fifo_en),  // R11 R12
    .in_data   (wr_data[`USD_DATA_MSB:0]),
    .in_ready  (txf_ready),
    .out_valid (txf_valid),
    .out_data  (txf_data),
    .out_ready (tx_load && fifo_en)
  );

  // Software registers; toggling the FIFO enable flushes both FIFOs
  always @(posedge core_clk) begin
    if (sys_rst) begin
      fifo_control_reg <= `USD_CTRL_RESET;
      divisor          <= `USD_DIV_RESET;
      irq_mask         <= `USD_IRQ_RESET;
    end else if (wr_en) begin
      case (addr)
        `USD_CTRL_ADDR: fifo_control_reg <= wr_data[1:0];
        `USD_DIV_ADDR:  divisor          <= wr_data[15:0];
        `USD_IMSK_ADDR: irq_mask         <= wr_data[2:0];
        default:        fifo_control_reg <= fifo_control_reg;
      endcase
    end
  end

  // Oversample enable: one pulse every divisor+1 clocks
  always @(posedge core_clk) begin
    if (sys_rst) begin
      div_cnt <= 16'h0000;
      tick    <= 1'b0;
    end else if (div_cnt == 16'h0000) begin
      div_cnt <= divisor;
      tick    <= 1'b1;
    end else begin
      div_cnt <= div_cnt - 16'h0001;
      tick    <= 1'b0;
    end
  end

  // Infrared pulse catcher: a short pulse anywhere in a bit means zero
  always @(posedge core_clk) begin
    if (sys_rst) begin
      ir_hit <= 1'b0;
    end else if (rx_sample) begin
      ir_hit <= 1'b0;
    end else if (sir_in) begin
      ir_hit <= 1'b1;
    end
  end

  // Receiver: start checked mid-bit, then eight data bits LSB first
  always @(posedge core_clk) begin
    if (sys_rst) begin
      rx_state <= ST_IDLE;
      rx_tick  <= 4'h0;
      rx_bit   <= 3'h0;
      rx_shift <= 8'h00;
      rx_byte  <= 8'h00;
      rx_done  <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      case (rx_state)
        ST_IDLE: begin
          rx_tick <= 4'h0;
          rx_bit  <= 3'h0;
          if (!rx_level) begin  // R2
            rx_state <= ST_START;
          end
        end
        ST_START: begin
          if (tick) begin
            rx_tick <= rx_tick + 4'h1;
          end
          if (rx_sample) begin
            rx_tick  <= 4'h0;
            // Serial mode: a glitch shorter than half a bit is not a start; infrared keeps any pulse via ir_hit
            rx_state <= rx_level ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (tick) begin
            rx_tick <= rx_tick + 4'h1;
          end
          if (rx_sample) begin
            rx_shift <= {rx_level, rx_shift[7:1]};
            rx_bit   <= rx_bit + 3'h1;
            if (rx_bit == `USD_BIT_LAST) begin
              rx_state <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (tick) begin
            rx_tick <= rx_tick + 4'h1;
          end
          if (rx_sample) begin
            // Framing errors are dropped silently
            rx_done  <= rx_level;
            rx_byte  <= rx_shift;
            rx_state <= ST_IDLE;
          end
        end
        default: rx_state <= ST_IDLE;
      endcase
    end
  end

  // Single receive buffer used while the FIFOs are off
  always @(posedge core_clk) begin
    if (sys_rst || flush) begin
      rx_buffer_reg <= 8'h00;
      rx_buf_valid  <= 1'b0;
    end else if (rx_done && !fifo_en) begin
      rx_buffer_reg <= rx_byte;  // R4
      rx_buf_valid  <= 1'b1;
    end else if (sh_rd && !fifo_en) begin
      rx_buf_valid  <= 1'b0;
    end
  end

  // Holding register used while the FIFOs are off; a write wins the load
  always @(posedge core_clk) begin
    if (sys_rst || flush) begin
      tx_holding_reg <= 8'h00;
      thr_full       <= 1'b0;
    end else if (sh_wr && !fifo_en) begin
      tx_holding_reg <= wr_data[`USD_DATA_MSB:0];  // R10 R13
      thr_full       <= 1'b1;                      // R9
    end else if (tx_load && !fifo_en) begin
      thr_full       <= 1'b0;
    end
  end

  // Transmitter: start, eight data bits LSB first, one stop bit
  always @(posedge core_clk) begin
    if (sys_rst) begin
      tx_state <= ST_IDLE;
      tx_tick  <= 4'h0;
      tx_bit   <= 3'h0;
      tx_shift <= 8'h00;
      tx_level <= 1'b1;
    end else begin
      case (tx_state)
        ST_IDLE: begin
          tx_tick  <= 4'h0;
          tx_bit   <= 3'h0;
          tx_level <= 1'b1;
          if (tx_avail) begin
            tx_shift <= fifo_en ? txf_data : tx_holding_reg;  // R7
            tx_level <= 1'b0;
            tx_state <= ST_START;
          end
        end
        ST_START: begin
          if (tick) begin
            tx_tick <= tx_tick + 4'h1;
            if (tx_tick == `USD_TICK_LAST) begin
              tx_level <= tx_shift[0];
              tx_state <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (tick) begin
            tx_tick <= tx_tick + 4'h1;
            if (tx_tick == `USD_TICK_LAST) begin
              tx_bit   <= tx_bit + 3'h1;
              tx_shift <= {1'b0, tx_shift[7:1]};
              tx_level <= (tx_bit == `USD_BIT_LAST) ? 1'b1 : tx_shift[1];
              if (tx_bit == `USD_BIT_LAST) begin
                tx_state <= ST_STOP;
              end
            end
          end
        end
        ST_STOP: begin
          if (tick) begin
            tx_tick <= tx_tick + 4'h1;
            if (tx_tick == `USD_TICK_LAST) begin
              tx_state <= ST_IDLE;
            end
          end
        end
        default: tx_state <= ST_IDLE;
      endcase
    end
  end

  // Pin drivers; the unused output idles at its inactive level
  always @(posedge core_clk) begin
    if (sys_rst) begin
      sout      <= 1'b1;
      sir_out_n <= 1'b1;
    end else begin
      sout      <= ir_mode ? 1'b1 : tx_level;  // R7
      sir_out_n <= ~(ir_mode && !tx_level && (tx_state != ST_IDLE) &&
                     (tx_tick < `USD_IR_PULSE));  // R7
    end
  end

  // Sticky overrun flag, cleared by reading line status; set wins
  always @(posedge core_clk) begin
    if (sys_rst) begin
      overrun <= 1'b0;
    end else if (oe_ev) begin
      overrun <= 1'b1;  // R4 R6
    end else if (rd_en && (addr == `USD_LSR_ADDR)) begin
      overrun <= 1'b0;
    end
  end

  // Event bits: write one clears, a new event in the same cycle wins
  always @* begin
    next_irq_status = irq_status;
    if (wr_en && (addr == `USD_IST_ADDR)) begin
      next_irq_status = irq_status & ~wr_data[2:0];
    end
    next_irq_status[`USD_EV_RX]   = next_irq_status[`USD_EV_RX] | rx_ev;
    next_irq_status[`USD_EV_OE]   = next_irq_status[`USD_EV_OE] | oe_ev;
    next_irq_status[`USD_EV_TX_HOLDING_EMPTY] = next_irq_status[`USD_EV_TX_HOLDING_EMPTY] |
                                    (tx_holding_empty && !tx_holding_empty_q);
  end

  // Interrupt status and level output
  always @(posedge core_clk) begin
    if (sys_rst) begin
      irq_status <= `USD_IRQ_RESET;
      tx_holding_empty_q     <= 1'b1;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      tx_holding_empty_q     <= tx_holding_empty;
      irq        <= |(next_irq_status & irq_mask);
    end
  end

  // Read data stand for one cycle after the strobe, zero otherwise
  always @(posedge core_clk) begin
    if (sys_rst) begin
      rd_data <= 32'h00000000;
    end else if (rd_en) begin
      rd_data <= 32'h00000000;
      if (is_shadow(addr)) begin
        rd_data[`USD_DATA_MSB:0] <= rx_head;  // R2 R5 R13
      end else begin
        case (addr)
          `USD_CTRL_ADDR: rd_data[1:0] <= fifo_control_reg;
          `USD_LSR_ADDR: begin
            rd_data[`USD_LSR_DR]   <= dr;  // R3
            rd_data[`USD_LSR_OE]   <= overrun;
            rd_data[`USD_LSR_TX_HOLDING_EMPTY] <= tx_holding_empty;
          end
          `USD_IST_ADDR:  rd_data[2:0]  <= irq_status;
          `USD_IMSK_ADDR: rd_data[2:0]  <= irq_mask;
          `USD_DIV_ADDR:  rd_data[15:0] <= divisor;
          default:        rd_data       <= 32'h00000000;
        endcase
      end
    end else begin
      rd_data <= 32'h00000000;
    end
  end

endmodule

// >>> rtl/usd_regs.vh
// Register map, field positions, reset values and counts of the data port
`ifndef USD_REGS_VH
`define USD_REGS_VH

// Sixteen word aliases of the data port; alias 11 sits at 0x5000115c
`define USD_SHADOW_BASE  32'h50001130
`define USD_SHADOW_11    32'h5000115c
`define USD_SHADOW_SPAN  32'h00000040

// Control, status and interrupt registers
`define USD_CTRL_ADDR    32'h50001180
`define USD_LSR_ADDR     32'h50001184
`define USD_IST_ADDR     32'h50001188
`define USD_IMSK_ADDR    32'h5000118c
`define USD_DIV_ADDR     32'h50001190

// Control fields
`define USD_CTRL_FIFO_EN 0
`define USD_CTRL_IR_MODE 1
`define USD_CTRL_RESET   2'h0

// Line status fields
`define USD_LSR_DR       0
`define USD_LSR_OE       1
`define USD_LSR_TX_HOLDING_EMPTY     5

// Interrupt status and mask fields
`define USD_EV_RX        0
`define USD_EV_OE        1
`define USD_EV_TX_HOLDING_EMPTY      2
`define USD_IRQ_RESET    3'h0

// Shadow data field
`define USD_DATA_MSB     7

// Baud divisor: one oversample tick every divisor+1 clocks
`define USD_DIV_RESET    16'h0035

// Character buffers: 16 entries of 8 bits
`define USD_FIFO_DEPTH   16
`define USD_FIFO_AW      4

// Sixteen ticks per bit; start checked mid-bit; infrared pulse 3/16 bit
`define USD_TICK_LAST    4'hf
`define USD_TICK_MID     4'h7
`define USD_IR_PULSE     4'h3
`define USD_BIT_LAST     3'h7

`endif

// >>> rtl/usd_fifo.v
// Character FIFO with valid/ready on both sides and a flush
`timescale 1ns/1ps
`include "usd_regs.vh"

module usd_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = `USD_FIFO_DEPTH,
  parameter AW    = `USD_FIFO_AW
) (
  input  wire             core_clk,
  input  wire             sys_rst,
  input  wire             flush,
  input  wire             in_valid,
  input  wire [WIDTH-1:0] in_data,
  output wire             in_ready,
  output wire             out_valid,
  output wire [WIDTH-1:0] out_data,
  input  wire             out_ready
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      fill;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  // Full refuses the push, so the stored entries are never disturbed
  assign in_ready  = (fill != DEPTH[AW:0]);
  assign out_valid = (fill != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];

  // Storage array needs no reset
  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level; the pointers wrap at the depth
  always @(posedge core_clk) begin
    if (sys_rst || flush) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      fill   <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        fill <= fill + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        fill <= fill - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule

// >>> tb/usd_port_sva.sv
// Port-level assertions for the UART data port, bound to usd_port
`timescale 1ns/1ps
`include "usd_regs.vh"

module usd_port_chk (
  input wire        core_clk,
  input wire        sys_rst,
  input wire [31:0] addr,
  input wire [31:0] wr_data,
  input wire        wr_en,
  input wire        rd_en,
  input wire [31:0] rd_data,
  input wire        sin,
  input wire        sir_in,
  input wire        sout,
  input wire        sir_out_n,
  input wire        irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // Decoded accesses that the properties key on
  wire alias_rd = rd_en && addr[1:0] == 2'h0 && addr >= `USD_SHADOW_BASE
                  && addr < `USD_SHADOW_BASE + `USD_SHADOW_SPAN;
  wire end_rd   = rd_en && addr == `USD_SHADOW_BASE + `USD_SHADOW_SPAN;
  wire mask_clr = wr_en && addr == `USD_IMSK_ADDR && wr_data[2:0] == 3'h0;

  // Minimum lengths hold at any divisor, so no divisor copy is needed
  sequence uart_start;
    !sout [*8];
  endsequence
  sequence ir_pulse;
    !sir_out_n [*3];
  endsequence

  rst_idle_a: assert property ($past(sys_rst) |->
    sout && sir_out_n && !irq && rd_data == 32'h0)
    else $error("outputs not idle after reset");
  rd_idle_zero_a: assert property (!$past(rd_en) |-> rd_data == 32'h0)
    else $error("read data outside its cycle");
  rsvd_zero_a: assert property ($past(alias_rd) |-> rd_data[31:8] == 24'h0)
    else $error("reserved data bits not zero");
  alias_end_a: assert property ($past(end_rd) |-> rd_data == 32'h0)
    else $error("read past last alias not zero");
  lines_excl_a: assert property (sout || sir_out_n)
    else $error("both serial outputs active");
  start_len_a: assert property ($fell(sout) |-> uart_start)
    else $error("start bit too short");
  ir_pulse_a: assert property ($fell(sir_out_n) |-> ir_pulse)
    else $error("infrared pulse too short");
  irq_mask_a: assert property ($past(mask_clr) |-> ##[0:1] !irq)
    else $error("interrupt stays up when masked");
endmodule

bind usd_port usd_port_chk usd_port_chk_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .sin(sin),
  .sir_in(sir_in), .sout(sout), .sir_out_n(sir_out_n), .irq(irq));

// >>> tb/usd_far_end.sv
// Far-end serial and infrared transceiver model, one clock per tick
`timescale 1ns/1ps

module usd_far_end (
  input  wire       core_clk,
  input  wire       ir,
  input  wire       sout,
  input  wire       sir_out_n,
  output reg        sin,
  output reg        sir_in,
  output reg  [7:0] got,
  output reg        got_stb
);
  reg [7:0] b;
  integer   i;

  // 8N1, LSB first, 16 clocks a bit; infrared zero is a 3-clock pulse
  task send(input [7:0] d);
    reg [9:0] f;
    integer   k;
    begin
      f = {1'b1, d, 1'b0};
      for (k = 0; k < 10; k = k + 1) begin
        sin <= ir ? 1'b1 : f[k];
        sir_in <= ir && !f[k];
        repeat (3) @(posedge core_clk);
        sir_in <= 1'b0;
        repeat (13) @(posedge core_clk);
      end
    end
  endtask

  // Decoder samples on the falling edge, away from the output updates
  initial begin
    sin = 1'b1;
    sir_in = 1'b0;
    got = 8'h00;
    got_stb = 1'b0;
    forever begin
      @(negedge core_clk);
      if (ir ? !sir_out_n : !sout) begin
        repeat (ir ? 1 : 8) @(negedge core_clk);
        for (i = 0; i < 8; i = i + 1) begin
          repeat (16) @(negedge core_clk);
          b[i] = ir ? sir_out_n : sout;
        end
        repeat (16) @(negedge core_clk);
        @(posedge core_clk);
        got <= b;
        got_stb <= 1'b1;
        @(posedge core_clk);
        got_stb <= 1'b0;
      end
    end
  end
endmodule

// >>> tb/usd_port_tb_top.sv
// Self-checking bench for the UART data port
`timescale 1ns/1ps
`include "usd_regs.vh"

module usd_port_tb_top;
  reg         core_clk;
  reg         sys_rst;
  reg  [31:0] addr;
  reg  [31:0] wr_data;
  reg         wr_en;
  reg         rd_en;
  reg         ir;
  reg         rd_seen;
  reg  [31:0] seed;
  reg  [7:0]  v [0:17];
  reg  [31:0] rd_q [$];
  reg  [7:0]  ser_q [$];
  wire [31:0] rd_data;
  wire [7:0]  got;
  wire        sin, sir_in, sout, sir_out_n, irq, got_stb;
  integer     bad_count, comparisons, k;

  usd_port usd_port_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .sin(sin), .sir_in(sir_in), .sout(sout),
    .sir_out_n(sir_out_n), .irq(irq));
  usd_far_end usd_far_end_inst (.core_clk(core_clk), .ir(ir), .sout(sout),
    .sir_out_n(sir_out_n), .sin(sin), .sir_in(sir_in), .got(got),
    .got_stb(got_stb));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task end_sim;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  // Every bus call sets both strobes once, so back-to-back cycles are safe
  task bus(input w, input r, input [31:0] a, input [31:0] d);
    begin
      wr_en <= w;
      rd_en <= r;
      addr <= a;
      wr_data <= d;
      @(posedge core_clk);
    end
  endtask
  task wr(input [31:0] a, input [31:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task rd(input [31:0] a, input [31:0] e);
    begin
      rd_q.push_back(e);
      bus(1'b0, 1'b1, a, {rnd(), 24'h0});
    end
  endtask
  task idle(input integer n);
    bus(1'b0, 1'b0, addr, wr_data);
    repeat (n - 1) @(posedge core_clk);
  endtask
  task send(input [7:0] d);
    begin
      idle(1);
      usd_far_end_inst.send(d);
    end
  endtask

  // Bounded wait: s=1 for the serial queue to drain, s=0 for irq == lv
  task wait_on(input s, input lv);
    integer n;
    begin
      idle(1);
      for (n = 0; n < 9000 && !(s ? ser_q.size() == 0 : irq === lv);
           n = n + 1)
        @(negedge core_clk);
      @(posedge core_clk);
      comparisons = comparisons + 1;
      if (n == 9000) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t: wait ran out", $time);
        end_sim;
      end
    end
  endtask

  // Watcher: oldest note against each result once it has settled
  always @(posedge core_clk) rd_seen <= rd_en;
  always @(negedge core_clk) begin
    if (rd_seen) begin
      comparisons = comparisons + 1;
      if (rd_data !== rd_q.pop_front()) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t: read data %h", $time, rd_data);
      end
    end
    if (got_stb === 1'b1) begin
      comparisons = comparisons + 1;
      if (ser_q.size() == 0 || got !== ser_q.pop_front()) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t: line byte %h", $time, got);
      end
    end
  end

  initial begin
    sys_rst = 1'b1;
    addr = 32'h0;
    wr_data = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    ir = 1'b0;
    seed = 32'd92;
    bad_count = 0;
    comparisons = 0;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(`USD_SHADOW_11, 32'h0);
    rd(`USD_SHADOW_BASE + `USD_SHADOW_SPAN, 32'h0);
    wr(`USD_DIV_ADDR, 32'h0);
    wr(`USD_IMSK_ADDR, 32'h1);
    // The divider takes a new divisor only when its old count runs out
    idle(60);
    // FIFOs off: one byte raises the interrupt, then an overrun
    v[0] = rnd();
    send(v[0]);
    wait_on(1'b0, 1'b1);
    rd(`USD_LSR_ADDR, 32'h21);
    rd(`USD_SHADOW_11, {24'h0, v[0]});
    wr(`USD_IST_ADDR, 32'h7);
    wait_on(1'b0, 1'b0);
    send(8'h11);
    send(8'h22);
    rd(`USD_LSR_ADDR, 32'h23);
    rd(`USD_SHADOW_11, 32'h22);
    rd(`USD_IST_ADDR, 32'h3);
    wr(`USD_IMSK_ADDR, 32'h0);
    wait_on(1'b0, 1'b0);
    // FIFOs off transmit: upper bits ignored, pending byte overwritten
    for (k = 0; k < 3; k = k + 1)
      v[k] = rnd();
    wr(`USD_SHADOW_BASE, {24'hffffff, v[0]});
    ser_q.push_back(v[0]);
    idle(5);
    wr(`USD_SHADOW_11, {24'h0, v[1]});
    wr(`USD_SHADOW_BASE + 32'h4, {24'h0, v[2]});
    ser_q.push_back(v[2]);
    rd(`USD_LSR_ADDR, 32'h0);
    wait_on(1'b1, 1'b0);
    // FIFOs on: one byte too many is dropped on both paths
    wr(`USD_CTRL_ADDR, 32'h1);
    for (k = 0; k <= `USD_FIFO_DEPTH; k = k + 1) begin
      v[k] = rnd();
      send(v[k]);
    end
    rd(`USD_LSR_ADDR, 32'h23);
    for (k = 0; k < `USD_FIFO_DEPTH; k = k + 1)
      rd(`USD_SHADOW_BASE + 4 * k, {24'h0, v[k]});
    for (k = 0; k <= `USD_FIFO_DEPTH + 1; k = k + 1) begin
      v[k] = rnd();
      wr(`USD_SHADOW_BASE + 4 * (k % 16), {24'h0, v[k]});
      if (k <= `USD_FIFO_DEPTH)
        ser_q.push_back(v[k]);
    end
    wait_on(1'b1, 1'b0);
    // Infrared mode, both directions
    wr(`USD_CTRL_ADDR, 32'h2);
    idle(2);
    ir <= 1'b1;
    v[0] = rnd();
    v[1] = rnd();
    send(v[0]);
    rd(`USD_SHADOW_11, {24'h0, v[0]});
    wr(`USD_SHADOW_11, {24'h0, v[1]});
    ser_q.push_back(v[1]);
    wait_on(1'b1, 1'b0);
    end_sim;
  end
endmodule
